//--- pkg/uhp_pkg.sv
// Package: constants, register map and carrier types of the ring/status block
package uhp_pkg;

	// ==========================================
	// Bus widths
	localparam int UHP_AW = 4;
	localparam int UHP_DW = 8;

	// ==========================================
	// Register offsets
	localparam logic [UHP_AW-1:0] UHP_ADDR_IER = 4'h1;
	localparam logic [UHP_AW-1:0] UHP_ADDR_MCR = 4'h4;
	localparam logic [UHP_AW-1:0] UHP_ADDR_MSR = 4'h6;
	localparam logic [UHP_AW-1:0] UHP_ADDR_ISR = 4'h7;

	// ==========================================
	// Field positions
	localparam int UHP_MCR_USER_OUT_A = 2;
	localparam int UHP_MCR_USER_OUT_B = 3;
	localparam int UHP_MCR_LOOP = 4;
	localparam int UHP_MSR_RING_TRAILING_EDGE_FLAG = 2;
	localparam int UHP_MSR_RING = 6;
	localparam int UHP_SRC_RXERR = 0;
	localparam int UHP_SRC_RXDATA = 1;
	localparam int UHP_SRC_THRE = 2;
	localparam int UHP_SRC_MODEM = 3;
	localparam int UHP_NSRC = 4;
	localparam int UHP_MCR_W = 5;

	// ==========================================
	// Receive clock oversampling
	localparam int UHP_RX_OVS = 16;
	localparam int UHP_RCNT_W = 4;
	localparam logic [UHP_RCNT_W-1:0] UHP_RCNT_LAST = 4'hF;
	localparam logic [UHP_RCNT_W-1:0] UHP_RCNT_ONE = 4'h1;

	// ==========================================
	// Carrier types
	typedef struct packed {
		logic [UHP_AW-1:0] addr;
		logic [UHP_DW-1:0] wdata;
		logic wr;
		logic read_strobe_low_n;
		logic read_strobe_high;
		logic select_high_a;
		logic select_high_b;
		logic select_low_n;
	} uhp_bus_s;

	typedef struct packed {
		logic rx_err;
		logic rx_data;
		logic rx_timeout;
		logic thr_empty;
	} uhp_evt_s;

	typedef struct packed {
		logic [UHP_NSRC-1:0] ier;
		logic [UHP_MCR_W-1:0] modem_control_reg;
		logic [UHP_NSRC-1:0] stat;
		logic ring_trailing_edge_flag;
		logic ring_prev;
		logic [UHP_DW-1:0] rdata;
		logic rd_oe;
		logic irq;
		logic out_a_n;
		logic out_b_n;
		logic rclk_prev;
		logic [UHP_RCNT_W-1:0] rcnt;
		logic rx_sample;
		logic rx_bit;
	} uhp_state_s;

	// ==========================================
	// Reset values
	localparam uhp_state_s UHP_STATE_RST = '{
		ier: 4'h0, modem_control_reg: 5'h00, stat: 4'h0, ring_trailing_edge_flag: 1'b0, ring_prev: 1'b1,
		rdata: 8'h00, rd_oe: 1'b0, irq: 1'b0, out_a_n: 1'b1, out_b_n: 1'b1,
		rclk_prev: 1'b0, rcnt: 4'h0, rx_sample: 1'b0, rx_bit: 1'b0};

endpackage

//--- verilog/uhp_ring_status.sv
// Module: host pins, interrupt, user outputs and ring status of a serial element
//
// Summary of operation
// - Interrupt output is high while any enabled interrupt is pending.
// - Sources: receive error, receive data or timeout, transmit empty, modem change.
// - Interrupt drops once serviced by a status read, and on master reset.
// - Master reset clears registers and forces outputs to reset levels.
// - User outputs go low when control bit 2 or bit 3 is set.
// - User outputs stay high on reset, in loopback, or with bits cleared.
// - Receiver section is timed by the 16x receive clock input.
// - Selected register is read when low strobe is low or high strobe high.
// - Modem status bit 6 shows the present ring indicator level.
// - Modem status bit 2 sets on ring input rising since last read.
// - That rising edge raises a modem interrupt when modem interrupts are enabled.
// - Block is selected only with both high selects high and low select low.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module uhp_ring_status
	import uhp_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic master_reset_in_i,
	// Host register bus
	input wire uhp_bus_s bus_i,
	output logic [UHP_DW-1:0] rdata_o,
	output logic rdata_oe_n_o,
	// Interrupt sources and output
	input wire uhp_evt_s evt_i,
	input wire logic fifo_mode_i,
	output logic irq_out_o,
	// Modem side
	input wire logic ring_detect_in_n_i,
	output logic user_out_a_n_o,
	output logic user_out_b_n_o,
	// Receive reference clock
	input wire logic rx_clk16_i,
	output logic rx_sample_o,
	output logic rx_bit_o
);

	// ==========================================
	// Decode helpers

	// Chip select qualification
	function automatic logic sel_ok(input uhp_bus_s b);
		sel_ok = b.select_high_a & b.select_high_b & ~b.select_low_n;
	endfunction

	// Either read strobe active
	function automatic logic rd_act(input uhp_bus_s b);
		rd_act = ~b.read_strobe_low_n | b.read_strobe_high;
	endfunction

	// ==========================================
	// State and decode

	uhp_state_s q, d;
	logic sel;
	logic wr_en;
	logic rd_en;
	logic ring_lvl;
	logic ring_rise;
	logic [UHP_NSRC-1:0] evt_vec;
	logic [UHP_DW-1:0] msr_val;

	// Bus qualification and modem status image
	always_comb begin
		sel = sel_ok(bus_i);
		wr_en = sel & bus_i.wr;
		rd_en = sel & rd_act(bus_i) & ~bus_i.wr;
		ring_lvl = ~ring_detect_in_n_i;
		ring_rise = ~q.ring_prev & ring_detect_in_n_i;
		msr_val = '0;
		msr_val[UHP_MSR_RING] = ring_lvl;
		msr_val[UHP_MSR_RING_TRAILING_EDGE_FLAG] = q.ring_trailing_edge_flag;
	end

	// Event vector from the four sources
	always_comb begin
		evt_vec = '0;
		evt_vec[UHP_SRC_RXERR] = evt_i.rx_err;
		evt_vec[UHP_SRC_RXDATA] = evt_i.rx_data | (evt_i.rx_timeout & fifo_mode_i);
		evt_vec[UHP_SRC_THRE] = evt_i.thr_empty;
		evt_vec[UHP_SRC_MODEM] = ring_rise & q.ier[UHP_SRC_MODEM];
	end

	// ==========================================
	// Next state

	always_comb begin
		d = q;
		d.rx_sample = 1'b0;
		d.rx_bit = 1'b0;
		d.rd_oe = 1'b0;
		// Register writes
		if (wr_en) begin
			case (bus_i.addr)
				UHP_ADDR_IER: d.ier = bus_i.wdata[UHP_NSRC-1:0];
				UHP_ADDR_MCR: d.modem_control_reg = bus_i.wdata[UHP_MCR_W-1:0];
				default: d.ier = q.ier;
			endcase
		end
		// Register reads, data in the following cycle
		if (rd_en) begin
			d.rd_oe = 1'b1;
			case (bus_i.addr)
				UHP_ADDR_IER: d.rdata = {{(UHP_DW-UHP_NSRC){1'b0}}, q.ier};
				UHP_ADDR_MCR: d.rdata = {{(UHP_DW-UHP_MCR_W){1'b0}}, q.modem_control_reg};
				UHP_ADDR_MSR: begin
					d.rdata = msr_val;
					d.ring_trailing_edge_flag = 1'b0;
					d.stat[UHP_SRC_MODEM] = 1'b0;
				end
				UHP_ADDR_ISR: begin
					d.rdata = {{(UHP_DW-UHP_NSRC){1'b0}}, q.stat};
					d.stat = '0;
				end
				default: d.rdata = '0;
			endcase
		end
		// Sets win over read clears
		if (ring_rise) begin
			d.ring_trailing_edge_flag = 1'b1;
		end
		d.stat = d.stat | evt_vec;
		d.ring_prev = ring_detect_in_n_i;
		// Interrupt level from enabled pending bits
		d.irq = |(d.stat & d.ier);
		// User outputs, forced high in loopback
		d.out_a_n = ~(d.modem_control_reg[UHP_MCR_USER_OUT_A] & ~d.modem_control_reg[UHP_MCR_LOOP]);
		d.out_b_n = ~(d.modem_control_reg[UHP_MCR_USER_OUT_B] & ~d.modem_control_reg[UHP_MCR_LOOP]);
		// Receive clock edge and bit-period divider
		d.rclk_prev = rx_clk16_i;
		if (rx_clk16_i & ~q.rclk_prev) begin
			d.rx_sample = 1'b1;
			if (q.rcnt == UHP_RCNT_LAST) begin
				d.rcnt = '0;
				d.rx_bit = 1'b1;
			end else begin
				d.rcnt = UHP_RCNT_W'(q.rcnt + UHP_RCNT_ONE);
			end
		end
	end

	// ==========================================
	// State register

	always_ff @(posedge clk_i) begin
		if (rst_i | master_reset_in_i) begin
			q <= UHP_STATE_RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// ==========================================
	// Outputs

	// All outputs straight from flops
	assign rdata_o = q.rdata;
	assign rdata_oe_n_o = ~q.rd_oe;
	assign irq_out_o = q.irq;
	assign user_out_a_n_o = q.out_a_n;
	assign user_out_b_n_o = q.out_b_n;
	assign rx_sample_o = q.rx_sample;
	assign rx_bit_o = q.rx_bit;

	// ==========================================
	// Assertions

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i | master_reset_in_i);

	AST_IRQ_LEVEL: assert property (
		irq_out_o == |(q.stat & q.ier))
		else $error("interrupt level differs from enabled pending bits");

	AST_SRC_RXERR: assert property (
		ce_i && evt_i.rx_err |=> q.stat[UHP_SRC_RXERR])
		else $error("receive error did not set its status bit");

	AST_ISR_CLEAR: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_ISR && evt_vec == '0
		|=> !irq_out_o && q.stat == '0)
		else $error("status read did not clear the interrupt");

	AST_MR_LEVELS: assert property (@(posedge clk_i) disable iff (rst_i)
		master_reset_in_i |=> !irq_out_o && user_out_a_n_o && user_out_b_n_o && q.ier == '0)
		else $error("master reset left outputs active");

	AST_OUT_A_LOW: assert property (
		ce_i && wr_en && bus_i.addr == UHP_ADDR_MCR && bus_i.wdata[UHP_MCR_USER_OUT_A]
		&& !bus_i.wdata[UHP_MCR_LOOP] |=> !user_out_a_n_o)
		else $error("user output a not driven low");

	AST_OUT_LOOP: assert property (
		q.modem_control_reg[UHP_MCR_LOOP] |-> user_out_a_n_o && user_out_b_n_o)
		else $error("user output low during loopback");

	AST_RX_DIV: assert property (
		rx_bit_o |-> rx_sample_o && q.rcnt == '0)
		else $error("bit tick not aligned with sample tick");

	AST_RD_DATA: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_MCR
		|=> !rdata_oe_n_o && rdata_o[UHP_MCR_W-1:0] == $past(q.modem_control_reg))
		else $error("read data missing after read strobe");

	AST_RING_LEVEL: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_MSR
		|=> rdata_o[UHP_MSR_RING] == !$past(ring_detect_in_n_i))
		else $error("ring level bit wrong");

	AST_RING_TRAILING_EDGE_FLAG_SET: assert property (
		ce_i && ring_rise |=> q.ring_trailing_edge_flag ##1 (q.ring_trailing_edge_flag || $past(rd_en)))
		else $error("ring trailing edge not flagged");

	AST_RING_IRQ: assert property (
		ce_i && ring_rise && q.ier[UHP_SRC_MODEM] && !(wr_en && bus_i.addr == UHP_ADDR_IER)
		|=> irq_out_o)
		else $error("ring edge raised no interrupt");

	AST_NOT_SEL: assert property (
		ce_i && !sel |=> rdata_oe_n_o)
		else $error("data driven while not selected");

	AST_RING_TRAILING_EDGE_FLAG_CLR: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_MSR && !ring_rise |=> !q.ring_trailing_edge_flag)
		else $error("modem status read kept ring flag");

	AST_MASKED: assert property (
		q.ier == '0 |-> !irq_out_o)
		else $error("interrupt raised with all enables clear");

	// Per-source, strobe and output checks
	AST_SRC_DATA: assert property (
		ce_i && evt_i.rx_data |=> q.stat[UHP_SRC_RXDATA])
		else $error("receive data did not set its status bit");

	AST_SRC_TOUT: assert property (
		ce_i && evt_i.rx_timeout && fifo_mode_i |=> q.stat[UHP_SRC_RXDATA])
		else $error("timeout in fifo mode did not set its status bit");

	AST_TOUT_IDLE: assert property (
		ce_i && evt_i.rx_timeout && !fifo_mode_i && !evt_i.rx_data && !q.stat[UHP_SRC_RXDATA]
		|=> !q.stat[UHP_SRC_RXDATA])
		else $error("timeout outside fifo mode set a status bit");

	AST_SRC_THRE: assert property (
		ce_i && evt_i.thr_empty |=> q.stat[UHP_SRC_THRE])
		else $error("transmit empty did not set its status bit");

	AST_ISR_DATA: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_ISR
		|=> rdata_o[UHP_NSRC-1:0] == $past(q.stat) && rdata_o[UHP_DW-1:UHP_NSRC] == '0)
		else $error("status read returned wrong bits");

	AST_OE_PULSE: assert property (
		ce_i && !rdata_oe_n_o && !rd_en |=> rdata_oe_n_o)
		else $error("data enable stayed low without a read");

	AST_RD_LOW: assert property (
		ce_i && sel && !bus_i.read_strobe_low_n && !bus_i.wr |=> !rdata_oe_n_o)
		else $error("low read strobe gave no data");

	AST_OUT_B_LOW: assert property (
		ce_i && wr_en && bus_i.addr == UHP_ADDR_MCR && bus_i.wdata[UHP_MCR_USER_OUT_B]
		&& !bus_i.wdata[UHP_MCR_LOOP] |=> !user_out_b_n_o)
		else $error("user output b not driven low");

	AST_OUT_CLEAR: assert property (
		ce_i && wr_en && bus_i.addr == UHP_ADDR_MCR && !bus_i.wdata[UHP_MCR_USER_OUT_A]
		&& !bus_i.wdata[UHP_MCR_USER_OUT_B] |=> user_out_a_n_o && user_out_b_n_o)
		else $error("user output low with its bit cleared");

	AST_RING_TRAILING_EDGE_FLAG_READ: assert property (
		ce_i && rd_en && bus_i.addr == UHP_ADDR_MSR
		|=> rdata_o[UHP_MSR_RING_TRAILING_EDGE_FLAG] == $past(q.ring_trailing_edge_flag))
		else $error("ring flag bit not reported");

	AST_RING_MASKED: assert property (
		ce_i && ring_rise && !q.ier[UHP_SRC_MODEM] && !q.stat[UHP_SRC_MODEM]
		|=> !q.stat[UHP_SRC_MODEM])
		else $error("disabled ring edge raised a modem request");

	AST_NOT_SEL_WR: assert property (
		ce_i && !sel |=> q.modem_control_reg == $past(q.modem_control_reg) && q.ier == $past(q.ier))
		else $error("register changed while not selected");

	AST_MR_REGS: assert property (@(posedge clk_i) disable iff (rst_i)
		master_reset_in_i |=> rdata_oe_n_o && q.modem_control_reg == '0 && q.stat == '0 && !q.ring_trailing_edge_flag)
		else $error("master reset left registers set");

	// Main scenarios
	COV_RING_IRQ: cover property (ce_i && ring_rise && q.ier[UHP_SRC_MODEM] ##1 irq_out_o);
	COV_ISR_READ: cover property (irq_out_o ##1 rd_en && bus_i.addr == UHP_ADDR_ISR);
	COV_OUT_LOW: cover property (!user_out_a_n_o && !user_out_b_n_o);
	COV_RX_BIT: cover property (rx_bit_o);
	COV_LOW_READ: cover property (rd_en && !bus_i.read_strobe_low_n);

endmodule

`default_nettype wire

//--- verification/uhp_modem_model.sv
// Modem-side model: ring indicator pin and 16x receive clock
`timescale 1ns/10ps
`default_nettype none
module uhp_modem_model (
	// Clock and control from bench
	input wire logic clk_i,
	input wire logic ring_on_i,
	// Modem pins
	output logic ring_detect_in_n_o,
	output logic rx_clk16_o
);
	logic [1:0] div_q = 2'h0;
	logic rclk_q = 1'b0;
	// Pin low while ringing, pulled high otherwise
	assign ring_detect_in_n_o = ~ring_on_i;
	assign rx_clk16_o = rclk_q;
	// Free running receive clock, eight system clocks a period
	always @(posedge clk_i) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) begin
			rclk_q <= ~rclk_q;
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Testbench of the ring and status block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import uhp_pkg::*;
;
	typedef struct packed {logic [7:0] modem_control_reg; logic [1:0] outs;} uhp_row_s;
	logic clk, rst, mrst, ring, oen, irq, ua, ub, ring_n, rclk, smp, bitp, fifo, lo_rd;
	logic [7:0] rd;
	uhp_bus_s bus;
	uhp_evt_s evt;
	int fails, n_tests, ns, nb;
	uhp_row_s rows [5] = '{'{8'h00, 2'h3}, '{8'h04, 2'h1}, '{8'h08, 2'h2},
		'{8'h0C, 2'h0}, '{8'h1C, 2'h3}};
	uhp_ring_status uhp_ring_status_i (.clk_i(clk), .rst_i(rst), .ce_i(1'b1),
		.master_reset_in_i(mrst), .bus_i(bus), .rdata_o(rd), .rdata_oe_n_o(oen),
		.evt_i(evt), .fifo_mode_i(fifo), .irq_out_o(irq), .ring_detect_in_n_i(ring_n),
		.user_out_a_n_o(ua), .user_out_b_n_o(ub), .rx_clk16_i(rclk),
		.rx_sample_o(smp), .rx_bit_o(bitp));
	uhp_modem_model uhp_modem_model_i (.clk_i(clk), .ring_on_i(ring),
		.ring_detect_in_n_o(ring_n), .rx_clk16_o(rclk));
	// ==========================================
	// Clock, counters and shared tasks
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		ns += int'(smp);
		nb += int'(bitp);
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk) bus.wr <= 1'b0;
		#1;
	endtask
	// Read, then look at data and enable in the answer cycle
	task automatic rdc(input logic [3:0] a, input logic [7:0] d, input logic e);
		@(posedge clk) bus.read_strobe_high <= ~lo_rd;
		bus.read_strobe_low_n <= ~lo_rd;
		bus.addr <= a;
		@(posedge clk) bus.read_strobe_high <= 1'b0;
		bus.read_strobe_low_n <= 1'b1;
		#1 chk(oen, e);
		chk(rd, d);
	endtask
	task automatic pulse(input uhp_evt_s e);
		@(posedge clk) evt <= e;
		@(posedge clk) evt <= '0;
		#1;
	endtask
	task automatic end_sim;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_sim();
	end
	// ==========================================
	// Main sequence
	initial begin
		rst = 1'b1;
		mrst = 1'b0;
		ring = 1'b0;
		evt = '0;
		fifo = 1'b0;
		lo_rd = 1'b0;
		bus = '{addr: 4'h0, wdata: 8'h00, wr: 1'b0, read_strobe_low_n: 1'b1,
			read_strobe_high: 1'b0, select_high_a: 1'b1, select_high_b: 1'b1,
			select_low_n: 1'b0};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1 chk({oen, irq, ua, ub}, 8'h0B);
		foreach (rows[i]) begin
			wr(UHP_ADDR_MCR, rows[i].modem_control_reg);
			chk({ua, ub}, rows[i].outs);
		end
		wr(UHP_ADDR_IER, 8'h01);
		pulse('{rx_err: 1'b1, default: 1'b0});
		chk(irq, 1'b1);
		rdc(UHP_ADDR_ISR, 8'h01, 1'b0);
		chk(irq, 1'b0);
		wr(UHP_ADDR_IER, 8'h00);
		pulse('1);
		chk(irq, 1'b0);
		rdc(UHP_ADDR_ISR, 8'h07, 1'b0);
		// Timeout counts only in fifo mode
		pulse('{rx_timeout: 1'b1, default: 1'b0});
		rdc(UHP_ADDR_ISR, 8'h00, 1'b0);
		@(posedge clk) fifo <= 1'b1;
		pulse('{rx_timeout: 1'b1, default: 1'b0});
		rdc(UHP_ADDR_ISR, 8'h02, 1'b0);
		wr(UHP_ADDR_IER, 8'h08);
		@(posedge clk) ring <= 1'b1;
		rdc(UHP_ADDR_MSR, 8'h40, 1'b0);
		@(posedge clk) ring <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'b1);
		rdc(UHP_ADDR_MSR, 8'h04, 1'b0);
		chk(irq, 1'b0);
		rdc(UHP_ADDR_MSR, 8'h00, 1'b0);
		// Deselected cycles are ignored
		@(posedge clk) bus.select_low_n <= 1'b1;
		wr(UHP_ADDR_MCR, 8'h04);
		chk(ua, 1'b1);
		rdc(UHP_ADDR_MSR, 8'h00, 1'b1);
		@(posedge clk) bus.select_low_n <= 1'b0;
		// Master reset drops interrupt and returns user outputs high
		wr(UHP_ADDR_MCR, 8'h0C);
		wr(UHP_ADDR_IER, 8'h01);
		pulse('{rx_err: 1'b1, default: 1'b0});
		chk({irq, ua, ub}, 8'h04);
		@(posedge clk) mrst <= 1'b1;
		@(posedge clk) mrst <= 1'b0;
		#1 chk({irq, ua, ub}, 8'h03);
		ns = 0;
		nb = 0;
		repeat (400) @(posedge clk);
		#1 chk(8'(ns > 40), 8'h01);
		chk(8'(nb), 8'(ns / UHP_RX_OVS));
		// Low read strobe alone, high strobe held low
		lo_rd = 1'b1;
		wr(UHP_ADDR_MCR, 8'h0C);
		rdc(UHP_ADDR_MCR, 8'h0C, 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
